/* rtl/rtb_pkg.sv */
package rtb_pkg;

  // Register port widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // Register offsets on the configuration port
  localparam logic [5:0] OFF_STATE = 6'h2c;
  localparam logic [5:0] OFF_ADC   = 6'h2d;
  localparam logic [5:0] OFF_DAC   = 6'h2e;
  localparam logic [5:0] OFF_TOP   = 6'h2f;
  localparam logic [5:0] OFF_SPARE = 6'h30;
  localparam logic [5:0] OFF_TXQ   = 6'h3e;
  localparam logic [5:0] OFF_RXQ   = 6'h3f;

  // Field positions
  localparam int ADC_OFF_BIT = 15;
  localparam int BIST_BIT    = 7;
  localparam int BATT_BIT    = 6;
  localparam int VC_BIT      = 5;
  localparam int PD_BIT      = 4;

  // Values after reset
  localparam logic        ADC_OFF_RST = 1'b0;
  localparam logic [14:0] DAC_RST     = 15'h0000;
  localparam logic [7:0]  TOP_RST     = 8'h10;
  localparam logic [15:0] SPARE_RST   = 16'h0000;

  // Transmit converter sources
  typedef enum logic [2:0] {
    RTB_SRC_MOD   = 3'h0,
    RTB_SRC_OVR   = 3'h1,
    RTB_SRC_ADCHI = 3'h2,
    RTB_SRC_FILT  = 3'h3,
    RTB_SRC_NOISE = 3'h4,
    RTB_SRC_ADCLO = 3'h5,
    RTB_SRC_RSSI  = 3'h6,
    RTB_SRC_HS    = 3'h7
  } rtb_src_t;

  // Analog test routing
  localparam logic [3:0] MODE_VC = 4'h7;
  localparam int         ROUTE_N = 9;

  // Byte queues and read answer
  localparam int QUEUE_AW   = 7;
  localparam int READ_LAT   = 2;

endpackage

/* rtl/rtb_queue_if.sv */
`timescale 1ns/1ps
interface rtb_queue_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic [7:0] pop_data;
  logic       pop_valid;
  logic       full;
  logic       empty;

  // Storage side and the side that fills and drains it
  modport store (input push, push_data, pop, output pop_data, pop_valid, full, empty);
  modport user  (output push, push_data, pop, input pop_data, pop_valid, full, empty);
endinterface

/* rtl/rtb_byte_queue.sv */
`timescale 1ns/1ps
module rtb_byte_queue (
  input wire logic   core_clk,
  input wire logic   reset_n,
  rtb_queue_if.store q
);

  logic [7:0]                    mem [2**rtb_pkg::QUEUE_AW];
  logic [rtb_pkg::QUEUE_AW:0]    wr_q;
  logic [rtb_pkg::QUEUE_AW:0]    rd_q;
  logic                          do_push;
  logic                          do_pop;

  // Extra pointer bit tells full from empty
  assign q.empty = (wr_q == rd_q);
  assign q.full  = (wr_q[rtb_pkg::QUEUE_AW] != rd_q[rtb_pkg::QUEUE_AW])
                && (wr_q[rtb_pkg::QUEUE_AW-1:0] == rd_q[rtb_pkg::QUEUE_AW-1:0]);
  assign do_push = q.push && !q.full;
  assign do_pop  = q.pop && !q.empty;

  // Byte store; no reset so it maps onto RAM
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_q[rtb_pkg::QUEUE_AW-1:0]] <= q.push_data;
    end
  end

  // Pointers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Registered read; a pop on empty gives no valid
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q.pop_data  <= 8'h00;
      q.pop_valid <= 1'b0;
    end else begin
      q.pop_valid <= do_pop;
      if (do_pop) begin
        q.pop_data <= mem[rd_q[rtb_pkg::QUEUE_AW-1:0]];
      end
    end
  end

endmodule

/* rtl/rtb_test_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// (R1) State register shows the live 6-bit frame control state code.
// (R2) ADC clock gate bit 15 set stops the ADC clock despite enable.
// (R3) ADC test register reads live I sample at 14:8, Q at 6:0.
// (R4) Three-bit source field picks one of eight transmit converter inputs.
// (R5) Override source drives I from bits 11:6, Q from 5:0; reset zero.
// (R6) Software also needs manual power override and analog mode 4 for tests.
// (R7) Bit 7 runs memory self-test, result routed to the selected pin.
// (R8) Bit 6 enables battery monitor test output; resets to zero.
// (R9) Analog test power-down bit 4 resets to one; zero powers up.
// (R10) Four-bit mode field routes the powered analog test module.
// (R11) In mode 7 only, bit 5 picks VC node output or drive.
// (R12) Spare register is 16-bit read/write, resets zero, no function.
// (R13) Software writes zero to all reserved bits.
// (R14) Transmit byte port is write-only; contents readable only via RAM.
// (R15) Host keeps crystal oscillator running before transmit port writes.
// (R16) Receive byte port reads and writes only while oscillator runs.
// (R17) Transmit write appends a byte; receive read pops the oldest byte.
module rtb_test_regs (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        xosc_running,
  input  wire logic [5:0]  present_state_code,
  input  wire logic        adc_enable,
  input  wire logic [6:0]  adc_i,
  input  wire logic [6:0]  adc_q,
  output logic             adc_clk_en,
  input  wire logic [11:0] mod_iq,
  input  wire logic [11:0] filt_iq,
  input  wire logic [11:0] noise_iq,
  input  wire logic [5:0]  rssi_mag,
  input  wire logic [11:0] hs_test_iq,
  output logic      [5:0]  dac_i,
  output logic      [5:0]  dac_q,
  input  wire logic        self_test_result,
  output logic             memory_self_test_run,
  output logic             self_test_pin,
  output logic             battery_test_output_en,
  output logic             analog_test_powerdown,
  output logic      [3:0]  analog_test_routing,
  output logic      [8:0]  analog_route_en,
  output logic             vco_node_drive_select,
  input  wire logic        tx_pop,
  output logic      [7:0]  tx_byte,
  output logic             tx_byte_valid,
  output logic             tx_empty,
  input  wire logic        rx_push,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_full
);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic        adc_off_q;
  logic [14:0] dac_ctl_q;
  logic [7:0]  top_ctl_q;
  logic [15:0] spare_q;
  logic        rd_pend_q;
  logic [5:0]  rd_addr_q;
  logic        rd_osc_q;
  logic [15:0] rdata_d;
  logic [3:0]  mode_eff;

  rtb_queue_if txq ();
  rtb_queue_if rxq ();

  // Address match, used by every write and read path
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  // Writes; reserved bits are simply not stored
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_off_q <= rtb_pkg::ADC_OFF_RST;
      dac_ctl_q <= rtb_pkg::DAC_RST;
      top_ctl_q <= rtb_pkg::TOP_RST; // R9
      spare_q   <= rtb_pkg::SPARE_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, rtb_pkg::OFF_ADC)) begin
        adc_off_q <= reg_wdata[rtb_pkg::ADC_OFF_BIT];
      end else if (hit(reg_addr, rtb_pkg::OFF_DAC)) begin
        dac_ctl_q <= reg_wdata[14:0]; // R5
      end else if (hit(reg_addr, rtb_pkg::OFF_TOP)) begin
        top_ctl_q <= reg_wdata[7:0];
      end else if (hit(reg_addr, rtb_pkg::OFF_SPARE)) begin
        spare_q <= reg_wdata; // R12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte queues

  // Host writes need the oscillator; demodulator pushes win over host writes
  assign txq.push      = reg_wr && hit(reg_addr, rtb_pkg::OFF_TXQ) && xosc_running; // R14 R17
  assign txq.push_data = reg_wdata[7:0];
  assign txq.pop       = tx_pop;
  assign rxq.push      = rx_push
                      || (reg_wr && hit(reg_addr, rtb_pkg::OFF_RXQ) && xosc_running); // R16
  assign rxq.push_data = rx_push ? rx_byte : reg_wdata[7:0];
  assign rxq.pop       = reg_rd && hit(reg_addr, rtb_pkg::OFF_RXQ) && xosc_running; // R17

  rtb_byte_queue u_txq (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .q        (txq)
  );

  rtb_byte_queue u_rxq (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .q        (rxq)
  );

  // Modulator side gets the popped byte one cycle after its pop
  assign tx_byte       = txq.pop_data;
  assign tx_byte_valid = txq.pop_valid;

  // Queue flags, registered so the top outputs stay flop-driven
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_empty <= 1'b1;
      rx_full  <= 1'b0;
    end else begin
      tx_empty <= txq.empty;
      rx_full  <= rxq.full;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Reads answer two cycles later so a popped receive byte is ready in time
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 6'h00;
      rd_osc_q  <= 1'b0;
    end else begin
      rd_pend_q <= reg_rd;
      rd_addr_q <= reg_addr;
      rd_osc_q  <= xosc_running;
    end
  end

  // Read data; reserved and unmapped bits read as zero
  always_comb begin
    rdata_d = 16'h0000;
    if (hit(rd_addr_q, rtb_pkg::OFF_STATE)) begin
      rdata_d = {10'h000, present_state_code}; // R1
    end else if (hit(rd_addr_q, rtb_pkg::OFF_ADC)) begin
      rdata_d = {adc_off_q, adc_i, 1'b0, adc_q}; // R3
    end else if (hit(rd_addr_q, rtb_pkg::OFF_DAC)) begin
      rdata_d = {1'b0, dac_ctl_q};
    end else if (hit(rd_addr_q, rtb_pkg::OFF_TOP)) begin
      rdata_d = {8'h00, top_ctl_q};
    end else if (hit(rd_addr_q, rtb_pkg::OFF_SPARE)) begin
      rdata_d = spare_q;
    end else if (hit(rd_addr_q, rtb_pkg::OFF_RXQ) && rd_osc_q && rxq.pop_valid) begin
      rdata_d = {8'h00, rxq.pop_data}; // R16
    end
  end

  // Answer register; the transmit port reads as zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pend_q;
      if (rd_pend_q) begin
        reg_rdata <= rdata_d; // R14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter control

  // ADC clock follows enable unless gated off
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_clk_en <= 1'b0;
    end else begin
      adc_clk_en <= adc_enable && !adc_off_q; // R2
    end
  end

  // Source select; the ADC taps split the 7-bit samples into high or low six
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_i <= 6'h00;
      dac_q <= 6'h00;
    end else begin
      case (rtb_pkg::rtb_src_t'(dac_ctl_q[14:12])) // R4
        rtb_pkg::RTB_SRC_MOD:   {dac_i, dac_q} <= mod_iq;
        rtb_pkg::RTB_SRC_OVR:   {dac_i, dac_q} <= dac_ctl_q[11:0]; // R5
        rtb_pkg::RTB_SRC_ADCHI: {dac_i, dac_q} <= {adc_i[6:1], adc_q[6:1]};
        rtb_pkg::RTB_SRC_FILT:  {dac_i, dac_q} <= filt_iq;
        rtb_pkg::RTB_SRC_NOISE: {dac_i, dac_q} <= noise_iq;
        rtb_pkg::RTB_SRC_ADCLO: {dac_i, dac_q} <= {adc_i[5:0], adc_q[5:0]};
        rtb_pkg::RTB_SRC_RSSI:  {dac_i, dac_q} <= {rssi_mag, rssi_mag};
        default:                {dac_i, dac_q} <= hs_test_iq;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test outputs

  // Self-test, battery monitor and analog module controls
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      memory_self_test_run   <= 1'b0;
      self_test_pin          <= 1'b0;
      battery_test_output_en <= 1'b0;
      analog_test_powerdown  <= 1'b1;
      analog_test_routing    <= 4'h0;
      vco_node_drive_select  <= 1'b0;
    end else begin
      memory_self_test_run   <= top_ctl_q[rtb_pkg::BIST_BIT]; // R7
      self_test_pin          <= top_ctl_q[rtb_pkg::BIST_BIT] && self_test_result; // R7
      battery_test_output_en <= top_ctl_q[rtb_pkg::BATT_BIT]; // R8
      analog_test_powerdown  <= top_ctl_q[rtb_pkg::PD_BIT]; // R9
      analog_test_routing    <= top_ctl_q[3:0];
      vco_node_drive_select  <= !top_ctl_q[rtb_pkg::PD_BIT]
                             && (top_ctl_q[3:0] == rtb_pkg::MODE_VC)
                             && top_ctl_q[rtb_pkg::VC_BIT]; // R11
    end
  end

  // Powered-down module routes nothing; modes above 8 route nothing either
  assign mode_eff = top_ctl_q[3:0];

  genvar g;
  generate
    for (g = 0; g < rtb_pkg::ROUTE_N; g++) begin : g_route
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          analog_route_en[g] <= 1'b0;
        end else begin
          analog_route_en[g] <= !top_ctl_q[rtb_pkg::PD_BIT]
                             && (mode_eff == 4'(g)); // R10
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  adc_gate_a: assert property ( // R2
    adc_off_q |=> !adc_clk_en)
    else $error("ADC clock ran while gated off");

  adc_run_a: assert property ( // R2
    (adc_enable && !adc_off_q) |=> adc_clk_en)
    else $error("ADC clock stopped while enabled");

  state_read_a: assert property ( // R1
    (reg_rd && hit(reg_addr, rtb_pkg::OFF_STATE))
    |-> ##2 reg_rvalid && (reg_rdata == {10'h000, $past(present_state_code)}))
    else $error("State readback wrong");

  adc_read_a: assert property ( // R3
    (reg_rd && hit(reg_addr, rtb_pkg::OFF_ADC))
    |-> ##2 (reg_rdata[14:8] == $past(adc_i)) && (reg_rdata[6:0] == $past(adc_q)))
    else $error("ADC sample readback wrong");

  dac_override_a: assert property ( // R5
    (dac_ctl_q[14:12] == 3'h1) |=> {dac_i, dac_q} == $past(dac_ctl_q[11:0]))
    else $error("Override values not on converters");

  dac_modulator_a: assert property ( // R4
    (dac_ctl_q[14:12] == 3'h0) |=> {dac_i, dac_q} == $past(mod_iq))
    else $error("Modulator not on converters");

  bist_pin_a: assert property ( // R7
    !memory_self_test_run |-> !self_test_pin)
    else $error("Self-test result out while idle");

  battery_en_a: assert property ( // R8
    (reg_wr && hit(reg_addr, rtb_pkg::OFF_TOP))
    |-> ##2 battery_test_output_en == $past(reg_wdata[6], 2))
    else $error("Battery test enable did not follow write");

  powerdown_a: assert property ( // R9
    top_ctl_q[rtb_pkg::PD_BIT] |=> (analog_route_en == 9'h000) && analog_test_powerdown)
    else $error("Analog routing active while powered down");

  vc_mode_a: assert property ( // R11
    vco_node_drive_select |-> (analog_test_routing == 4'h7) && !analog_test_powerdown)
    else $error("VC drive outside mode 7");

  spare_rw_a: assert property ( // R12
    (reg_wr && hit(reg_addr, rtb_pkg::OFF_SPARE)) |=> spare_q == $past(reg_wdata))
    else $error("Spare register did not store write");

  tx_append_a: assert property ( // R17
    (reg_wr && hit(reg_addr, rtb_pkg::OFF_TXQ) && xosc_running && !tx_pop) |=> !txq.empty)
    else $error("Transmit byte not appended");

  osc_off_a: assert property ( // R16
    (reg_rd && hit(reg_addr, rtb_pkg::OFF_RXQ) && !xosc_running)
    |-> !rxq.pop ##2 (reg_rdata == 16'h0000))
    else $error("Receive port read without oscillator");

  tx_pop_a: assert property ( // R17
    (tx_pop && !txq.empty) |=> tx_byte_valid)
    else $error("Transmit pop gave no byte");

  rx_pop_a: assert property ( // R17
    (reg_rd && hit(reg_addr, rtb_pkg::OFF_RXQ) && xosc_running && !rxq.empty)
    |=> rxq.pop_valid)
    else $error("Receive read did not pop");

  route_onehot_a: assert property ( // R10
    $onehot0(analog_route_en))
    else $error("More than one analog route enabled");

  tx_read_a: assert property ( // R14
    (reg_rd && hit(reg_addr, rtb_pkg::OFF_TXQ)) |-> ##2 (reg_rdata == 16'h0000))
    else $error("Transmit port returned data");

  override_c: cover property (
    (dac_ctl_q[14:12] == 3'h1) ##1 (dac_i != 6'h00));

  rx_read_c: cover property (
    rxq.pop ##1 rxq.pop_valid ##1 reg_rvalid);

  vc_drive_c: cover property (
    vco_node_drive_select);

  tx_pop_c: cover property (
    tx_pop ##1 tx_byte_valid);

endmodule

/* verification/rtb_host_model.sv */
`timescale 1ns/1ps
// Host controller on the register port; write and read strobe changes land 1 ns after a rising edge
module rtb_host_model (
  input  wire logic        core_clk,
  input  wire logic        reg_rvalid,
  input  wire logic [15:0] reg_rdata,
  output logic      [5:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic             xosc_running
);
  // Idle port at time zero, oscillator already up
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    xosc_running = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reserved positions of mapped registers are zero in every write strobe
  function automatic logic [15:0] wmask(input logic [5:0] a);
    case (a)
      6'h2c: return 16'h0000;
      6'h2d: return 16'h8000;
      6'h2e: return 16'h7fff;
      6'h2f, 6'h3e, 6'h3f: return 16'h00ff;
      default: return 16'hffff;
    endcase
  endfunction

  // One write strobe; lines are inverted afterwards so stale values never look valid
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d & wmask(a);
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask

  // One read strobe, then a bounded wait for the answer pulse
  task automatic rd(input logic [5:0] a, output logic [15:0] q);
    int n;
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    q = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
  endtask

  // Oscillator state as the host keeps it
  task automatic osc(input logic b);
    xosc_running = b;
  endtask
endmodule

/* verification/radio_test_register_bank_tb.sv */
`timescale 1ns/1ps
module radio_test_register_bank_tb;
  logic        core_clk, reset_n, reg_wr, reg_rd, reg_rvalid, xosc_running, adc_enable;
  logic        adc_clk_en, self_test_result, memory_self_test_run, self_test_pin;
  logic        battery_test_output_en, analog_test_powerdown, vco_node_drive_select;
  logic        tx_pop, tx_byte_valid, tx_empty, rx_push, rx_full;
  logic [5:0]  reg_addr, present_state_code, rssi_mag, dac_i, dac_q;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic [6:0]  adc_i, adc_q;
  logic [11:0] mod_iq, filt_iq, noise_iq, hs_test_iq;
  logic [3:0]  analog_test_routing;
  logic [8:0]  analog_route_en;
  logic [7:0]  tx_byte, rx_byte;
  int          num_errors, checks, i;

  // Rows: offset, value written, value read back
  localparam logic [37:0] ROWS [6] = '{
    {6'h2e, 16'h7fff, 16'h7fff},
    {6'h2f, 16'h00ff, 16'h00ff},
    {6'h30, 16'ha5c3, 16'ha5c3},
    {6'h2c, 16'h0015, 16'h002b},
    {6'h3e, 16'h0077, 16'h0000},
    {6'h00, 16'h1234, 16'h0000}
  };
  localparam logic [7:0] TXE [3] = '{8'h77, 8'h81, 8'hfe};
  localparam logic [7:0] RXE [3] = '{8'h3c, 8'hc3, 8'h99};

  rtb_test_regs u_rtb_test_regs (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .xosc_running, .present_state_code, .adc_enable, .adc_i, .adc_q, .adc_clk_en, .mod_iq,
    .filt_iq, .noise_iq, .rssi_mag, .hs_test_iq, .dac_i, .dac_q, .self_test_result,
    .memory_self_test_run, .self_test_pin, .battery_test_output_en, .analog_test_powerdown,
    .analog_test_routing, .analog_route_en, .vco_node_drive_select, .tx_pop, .tx_byte,
    .tx_byte_valid, .tx_empty, .rx_push, .rx_byte, .rx_full
  );

  rtb_host_model u_rtb_host_model (
    .core_clk, .reg_rvalid, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .xosc_running
  );

  // Free running 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask

  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic w(input logic [5:0] a, input logic [15:0] d);
    u_rtb_host_model.wr(a, d);
  endtask

  task automatic r(input logic [5:0] a, output logic [15:0] d);
    u_rtb_host_model.rd(a, d);
  endtask

  // Registered outputs follow their cause by one edge
  task automatic wt;
    @(posedge core_clk);
    #1;
  endtask

  task automatic rst;
    reset_n = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
  endtask

  task automatic pop;
    wt;
    tx_pop = 1'b1;
    wt;
    tx_pop = 1'b0;
  endtask

  task automatic push(input logic [7:0] b);
    wt;
    rx_byte = b;
    rx_push = 1'b1;
    wt;
    rx_push = 1'b0;
    rx_byte = ~b;
  endtask

  // Expected converter pair for each source code
  function automatic logic [11:0] dexp(input logic [2:0] s);
    case (s)
      3'h0: return mod_iq;
      3'h1: return 12'haa5;
      3'h2: return {adc_i[6:1], adc_q[6:1]};
      3'h3: return filt_iq;
      3'h4: return noise_iq;
      3'h5: return {adc_i[5:0], adc_q[5:0]};
      3'h6: return {rssi_mag, rssi_mag};
      default: return hs_test_iq;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, well beyond the length of the sequence below
  initial begin
    #40000;
    num_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    num_errors = 0;
    checks = 0;
    present_state_code = 6'h2b;
    adc_enable = 1'b1;
    adc_i = 7'h5b;
    adc_q = 7'h26;
    mod_iq = 12'h9c3;
    filt_iq = 12'h5a6;
    noise_iq = 12'h3e1;
    hs_test_iq = 12'hc7d;
    rssi_mag = 6'h2d;
    self_test_result = 1'b1;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_byte = 8'h00;
    rst;
    chk(16'({analog_test_powerdown, tx_empty}), 16'h0003);
    r(6'h2d, q);
    chk(q, {1'b0, adc_i, 1'b0, adc_q});
    chk(16'(adc_clk_en), 16'h0001);
    r(6'h2e, q);
    chk(q, 16'h0000);
    r(6'h2f, q);
    chk(q, 16'h0010);
    r(6'h30, q);
    chk(q, 16'h0000);
    for (i = 0; i < 6; i++) begin
      w(ROWS[i][37:32], ROWS[i][31:16]);
      r(ROWS[i][37:32], q);
      chk(q, ROWS[i][15:0]);
    end
    present_state_code = 6'h11;
    r(6'h2c, q);
    chk(q, 16'h0011);
    // Every converter source with the analog module in mode 4
    w(6'h2f, 16'h0004);
    for (i = 0; i < 8; i++) begin
      w(6'h2e, {1'b0, 3'(i), 12'haa5});
      wt;
      chk({4'h0, dac_i, dac_q}, {4'h0, dexp(3'(i))});
    end
    // Clock gate against enable
    w(6'h2d, 16'h8000);
    wt;
    chk(16'(adc_clk_en), 16'h0000);
    r(6'h2d, q);
    chk(q, {1'b1, adc_i, 1'b0, adc_q});
    adc_enable = 1'b0;
    w(6'h2d, 16'h0000);
    wt;
    chk(16'(adc_clk_en), 16'h0000);
    adc_enable = 1'b1;
    wt;
    chk(16'(adc_clk_en), 16'h0001);
    // Routing modes, one past the last legal one, drive select always set
    for (i = 0; i < 10; i++) begin
      w(6'h2f, {10'h000, 1'b1, 1'b0, 4'(i)});
      wt;
      chk({analog_test_routing, 3'h0, (i < 9) ? 9'(1 << i) : 9'h000}, {4'(i), 12'h000} |
          16'(analog_route_en));
      chk(16'(vco_node_drive_select), 16'(i == 7));
    end
    // Powered down in mode 7 kills routing and drive select
    w(6'h2f, 16'h00f7);
    wt;
    chk(16'({memory_self_test_run, self_test_pin, battery_test_output_en,
             analog_test_powerdown, vco_node_drive_select, analog_route_en}), 16'h3c00);
    self_test_result = 1'b0;
    wt;
    wt;
    chk(16'(self_test_pin), 16'h0000);
    w(6'h2f, 16'h0010);
    wt;
    chk(16'({memory_self_test_run, battery_test_output_en, analog_test_powerdown}), 16'h0001);
    // Transmit port: a write with the oscillator stopped is lost
    w(6'h3e, 16'h0081);
    u_rtb_host_model.osc(1'b0);
    w(6'h3e, 16'h0055);
    u_rtb_host_model.osc(1'b1);
    w(6'h3e, 16'h00fe);
    for (i = 0; i < 3; i++) begin
      pop;
      chk(16'({tx_byte_valid, tx_byte}), {7'h00, 1'b1, TXE[i]});
    end
    wt;
    chk(16'(tx_empty), 16'h0001);
    pop;
    chk(16'(tx_byte_valid), 16'h0000);
    // Receive port: pushes and host write, stopped oscillator read pops nothing
    push(8'h3c);
    push(8'hc3);
    w(6'h3f, 16'h0099);
    u_rtb_host_model.osc(1'b0);
    r(6'h3f, q);
    chk(q, 16'h0000);
    u_rtb_host_model.osc(1'b1);
    for (i = 0; i < 4; i++) begin
      r(6'h3f, q);
      chk(q, (i < 3) ? {8'h00, RXE[i]} : 16'h0000);
    end
    // Receive queue reports full at 128 bytes; one read frees a slot
    for (i = 0; i < 128; i++) begin
      push(8'(i + 1));
    end
    wt;
    chk(16'(rx_full), 16'h0001);
    push(8'hee);
    r(6'h3f, q);
    chk(q, 16'h0001);
    chk(16'(rx_full), 16'h0000);
    // Second reset in mid-run with live contents
    w(6'h30, 16'h5a5a);
    push(8'h42);
    rst;
    r(6'h30, q);
    chk(q, 16'h0000);
    r(6'h2f, q);
    chk(q, 16'h0010);
    r(6'h3f, q);
    chk(q, 16'h0000);
    chk(16'(tx_empty), 16'h0001);
    chk(16'(rx_full), 16'h0000);
    summarize();
  end
endmodule
